/* File: src/aims_pkg.sv */
package aims_pkg;

    // ***************************************************************
    // register map
    // ***************************************************************
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_REMOTE = 4'h8;

    // control register fields
    localparam int CTRL_RUN = 0;
    localparam int CTRL_PRE = 1;
    localparam int CTRL_DIFF = 2;
    localparam int CTRL_RMT = 3;
    localparam int CTRL_CNT_LO = 4;
    localparam int CTRL_CNT_W = 4;
    localparam logic [31:0] CTRL_RESET = 32'h00000030;

    // status register fields
    localparam int STAT_STATE_LO = 0;
    localparam int STAT_FRAMES_LO = 8;
    localparam int FRAME_CNT_W = 16;

    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ***************************************************************
    // frame timing and state sequencing; tick values in slow clock cycles
    // ***************************************************************
    localparam int SLOW_CLOCK_HZ = 32768;
    localparam logic [3:0] FRAME_TICKS = 4'hD;
    localparam logic [3:0] SLOT_TICKS = 4'h3;
    localparam logic [3:0] REMOTE_TICK = 4'h7;
    localparam logic [3:0] MIN_STATES = 4'h1;
    localparam logic [3:0] SMALL_STATES = 4'h3;
    localparam logic [3:0] LARGE_STATES = 4'h4;
    localparam logic [3:0] REMOTE_SLOT = 4'h2;
    localparam logic [3:0] FIRST_STATE = 4'h1;

    // compute-engine ram layout
    localparam int RAM_ADDR_W = 4;
    localparam logic [3:0] RAM_REMOTE_ADDR = 4'h8;
    localparam int ADC_W = 22;
    localparam int ACC_W = 32;

    typedef enum logic [1:0] {
        FR_IDLE = 2'b00,
        FR_SLOT = 2'b01,
        FR_TAIL = 2'b11
    } aims_frame_e;

    typedef struct packed {
        logic [RAM_ADDR_W-1:0] addr;
        logic [ACC_W-1:0] data;
    } aims_ram_wr_s;

    typedef struct packed {
        logic preamp_enable;
        logic first_current_differential_enable;
        logic remote_sensor_enable;
        logic second_current_local_analog;
    } aims_afe_cfg_s;

endpackage

/* File: src/aims_fir_decim.sv */
`timescale 1ns/100ps
// boxcar decimator: sums converter output over one slot
module aims_fir_decim (
    // clock and control
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic clk_en,
    // converter stream
    input wire logic sample_valid,
    input wire logic [aims_pkg::ADC_W-1:0] sample_data,
    input wire logic gather,
    input wire logic dump,
    // decimated result
    output logic [aims_pkg::ACC_W-1:0] result,
    output logic result_valid
);
    import aims_pkg::*;

    logic [ACC_W-1:0] acc;
    logic [ACC_W-1:0] ext;

    // sign extend the converter word
    assign ext = {{(ACC_W-ADC_W){sample_data[ADC_W-1]}}, sample_data};

    // accumulate inside the slot, restart on dump; a stop mid-slot leaves its sum for the next run's first slot
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            acc <= '0;
        end else if (clk_en) begin
            if (dump) begin
                acc <= '0;
            end else if (gather && sample_valid) begin
                acc <= acc + ext;
            end
        end
    end

    // result register, one cycle after the dump
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            result <= '0;
            result_valid <= 1'b0;
        end else if (clk_en) begin
            result_valid <= dump;
            if (dump) begin
                result <= (gather && sample_valid) ? acc + ext : acc;
            end
        end
    end

endmodule

/* File: src/aims_sequencer.sv */
`timescale 1ns/100ps
//
// Contract
// R1: each frame starts at state 1 and steps through frame_state_count states.
// R2: a frame lasts exactly 13 slow clock cycles for three or four inputs.
// R3: small variant sequences three inputs, large variant adds second voltage.
// R4: preamp enable routes first current pair through the x8 preamplifier.
// R5: first current pair selectable differential or single-ended by its bit.
// R6: differential enable makes first current pair a differential shunt input.
// R7: remote enable turns second current pair into a balanced digital link.
// R8: remote enable low keeps second current pair as local analog inputs.
// R9: first current pair never offers remote-sensor mode.
// R10: in remote mode slot 2 is dropped; remote samples go straight to RAM.
// R11: remote channel sampled in the frame's second half, fixed to voltage.
// R12: multiplexed converter output is decimated and stored in engine RAM.
// R13: slot counter runs on slow clock; one frame-start strobe per frame.
module aims_sequencer #(
    parameter bit HAS_SECOND_VOLTAGE = 1'b1
) (
    // clock, reset, enable
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic clk_en,
    // axi4-lite slave
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // slow clock pin and converter stream
    input wire logic slow_clock_32k,
    input wire logic adc_valid,
    input wire logic [aims_pkg::ADC_W-1:0] adc_data,
    // remote sensor samples from the digital link
    input wire logic remote_valid,
    input wire logic [aims_pkg::ACC_W-1:0] remote_data,
    // analog front end control
    output aims_pkg::aims_afe_cfg_s afe_cfg,
    output logic [3:0] mux_state,
    output logic frame_start,
    // compute-engine ram write port
    output logic ram_we,
    output aims_pkg::aims_ram_wr_s ram_wr
);
    import aims_pkg::*;

    // ***************************************************************
    // functions
    // ***************************************************************

    // byte-lane merge used by the control register write
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) res[i*8 +: 8] = wd[i*8 +: 8];
        end
        return res;
    endfunction

    // clamp requested state count to what this variant can sequence
    function automatic logic [3:0] clamp_states(input logic [3:0] req);
        logic [3:0] top;
        top = HAS_SECOND_VOLTAGE ? LARGE_STATES : SMALL_STATES;
        if (req < MIN_STATES) return MIN_STATES;
        return (req > top) ? top : req;
    endfunction

    // ***************************************************************
    // registers and bus slave
    // ***************************************************************
    logic [31:0] ctrl;
    logic [31:0] remote_last;
    logic [FRAME_CNT_W-1:0] frame_cnt;
    logic aw_held;
    logic w_held;
    logic [3:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic do_write;

    // address and data are taken in either order, then answered together
    assign do_write = aw_held && w_held && !s_axi_bvalid;

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_data <= '0;
            w_strb <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else if (clk_en) begin
            s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
            s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awready && s_axi_awvalid) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (do_write) begin
                aw_held <= 1'b0;
            end
            if (s_axi_wready && s_axi_wvalid) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (do_write) begin
                w_held <= 1'b0;
            end
        end
    end

    // write response and control register
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            ctrl <= CTRL_RESET;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (clk_en) begin
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_addr == ADDR_CTRL) ? RESP_OKAY : RESP_SLVERR;
                if (aw_addr == ADDR_CTRL) ctrl <= merge(ctrl, w_data, w_strb);
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ***************************************************************
    // slow clock synchroniser and frame timing
    // ***************************************************************
    logic slow_s1;
    logic slow_s2;
    logic slow_s3;
    logic tick;
    logic [3:0] tick_cnt;
    logic [3:0] active_states;
    logic [3:0] state;
    logic [3:0] slot_pos;
    aims_frame_e frame;
    logic running;
    logic slot_end;

    // slow clock is an asynchronous pin; first flop feeds only the second
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            slow_s1 <= 1'b0;
            slow_s2 <= 1'b0;
            slow_s3 <= 1'b0;
        end else if (clk_en) begin
            slow_s1 <= slow_clock_32k;
            slow_s2 <= slow_s1;
            slow_s3 <= slow_s2;
        end
    end

    assign tick = slow_s2 && !slow_s3;
    assign running = ctrl[CTRL_RUN];
    // end of a slot: last slow cycle of an occupied slot
    assign slot_end = tick && (frame == FR_SLOT) && (slot_pos == SLOT_TICKS - 4'h1);

    // R2: frame length 13 ticks
    // R13: slot counter on slow clock
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            tick_cnt <= '0;
            slot_pos <= '0;
            state <= '0;
            frame <= FR_IDLE;
            active_states <= SMALL_STATES;
            frame_start <= 1'b0;
            frame_cnt <= '0;
        end else if (clk_en) begin
            frame_start <= 1'b0;
            if (!running) begin
                frame <= FR_IDLE;
                state <= '0;
                tick_cnt <= '0;
                slot_pos <= '0;
            end else if (tick) begin
                tick_cnt <= (tick_cnt == FRAME_TICKS - 4'h1) ? 4'h0 : tick_cnt + 4'h1;
                if (tick_cnt == FRAME_TICKS - 4'h1 || frame == FR_IDLE) begin
                    // R1: frame begins at state 1
                    // R3: count limited per variant
                    frame <= FR_SLOT;
                    state <= FIRST_STATE;
                    slot_pos <= '0;
                    active_states <= clamp_states(ctrl[CTRL_CNT_LO +: CTRL_CNT_W]);
                    frame_start <= 1'b1;
                    frame_cnt <= frame_cnt + 1'b1;
                    tick_cnt <= '0;
                end else if (frame == FR_SLOT) begin
                    if (slot_pos == SLOT_TICKS - 4'h1) begin
                        // R1: stop after the set number of states
                        slot_pos <= '0;
                        if (state == active_states) begin
                            frame <= FR_TAIL;
                            state <= '0;
                        end else begin
                            state <= state + 4'h1;
                        end
                    end else begin
                        slot_pos <= slot_pos + 4'h1;
                    end
                end
            end
        end
    end

    // ***************************************************************
    // front end configuration
    // ***************************************************************

    // R4: preamp drive
    // R5: single-ended or differential
    // R6: differential shunt input
    // R7: second pair to digital link
    // R8: local analog when remote off
    // R9: no remote mode on first pair
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            afe_cfg <= '0;
            mux_state <= '0;
        end else if (clk_en) begin
            afe_cfg.preamp_enable <= ctrl[CTRL_PRE];
            afe_cfg.first_current_differential_enable <= ctrl[CTRL_DIFF];
            afe_cfg.remote_sensor_enable <= ctrl[CTRL_RMT];
            afe_cfg.second_current_local_analog <= !ctrl[CTRL_RMT];
            mux_state <= state;
        end
    end

    // ***************************************************************
    // decimation and ram writes
    // ***************************************************************
    logic [ACC_W-1:0] fir_result;
    logic fir_valid;
    logic [3:0] dump_slot;
    logic remote_due;
    logic [ACC_W-1:0] remote_hold;

    // R12: decimate multiplexed samples
    aims_fir_decim u_fir (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .clk_en(clk_en),
        .sample_valid(adc_valid),
        .sample_data(adc_data),
        .gather(frame == FR_SLOT),
        .dump(slot_end),
        .result(fir_result),
        .result_valid(fir_valid)
    );

    // R11: remote sample at fixed tick in second half
    assign remote_due = tick && running && ctrl[CTRL_RMT] && (tick_cnt == REMOTE_TICK - 4'h1);

    // remember which slot is dumping; latch latest remote word
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            dump_slot <= '0;
            remote_hold <= '0;
            remote_last <= '0;
        end else if (clk_en) begin
            if (slot_end) dump_slot <= state;
            if (remote_valid) remote_hold <= remote_data;
            // a word arriving on the due cycle wins over the held one
            if (remote_due) remote_last <= remote_valid ? remote_data : remote_hold;
        end
    end

    // R10: slot 2 dropped, remote direct to ram
    // R12: results stored in ram
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            ram_we <= 1'b0;
            ram_wr <= '0;
        end else if (clk_en) begin
            ram_we <= 1'b0;
            if (remote_due) begin
                ram_we <= 1'b1;
                ram_wr.addr <= RAM_REMOTE_ADDR;
                ram_wr.data <= remote_valid ? remote_data : remote_hold;
            end else if (fir_valid && !(ctrl[CTRL_RMT] && dump_slot == REMOTE_SLOT)) begin
                ram_we <= 1'b1;
                ram_wr.addr <= dump_slot;
                ram_wr.data <= fir_result;
            end
        end
    end

    // ***************************************************************
    // read channel
    // ***************************************************************
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else if (clk_en) begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
            if (s_axi_arready && s_axi_arvalid) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= RESP_OKAY;
                s_axi_rdata <= '0;
                case (s_axi_araddr)
                    ADDR_CTRL: s_axi_rdata <= ctrl;
                    ADDR_STATUS: begin
                        s_axi_rdata[STAT_STATE_LO +: 4] <= state;
                        s_axi_rdata[STAT_FRAMES_LO +: FRAME_CNT_W] <= frame_cnt;
                    end
                    ADDR_REMOTE: s_axi_rdata <= remote_last;
                    default: s_axi_rresp <= RESP_SLVERR;
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule

/* File: verification/aims_sequencer_asserts.sv */
`timescale 1ns/100ps
module aims_sequencer_asserts #(
    parameter bit HAS_SECOND_VOLTAGE = 1'b1
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic clk_en,
    // slow clock and sequencer outputs
    input wire logic slow_clock_32k,
    input wire aims_pkg::aims_afe_cfg_s afe_cfg,
    input wire logic [3:0] mux_state,
    input wire logic frame_start,
    input wire logic ram_we,
    input wire aims_pkg::aims_ram_wr_s ram_wr
);
    import aims_pkg::*;

    // ***************************************************************
    // tick counting since frame start
    // ***************************************************************
    logic slow_q;
    logic seen;
    logic [4:0] ticks;
    logic [3:0] top_state;
    assign top_state = HAS_SECOND_VOLTAGE ? LARGE_STATES : SMALL_STATES;

    // raw pin edges; the design's sync delay is constant, so spacing holds
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            slow_q <= 1'b0;
            ticks <= 5'h00;
            seen <= 1'b0;
        end else begin
            slow_q <= slow_clock_32k;
            if (frame_start)
                ticks <= 5'h00;
            else if (slow_clock_32k && !slow_q && ticks != 5'h1F)
                ticks <= ticks + 5'h01;
            // a long idle gap or a freeze means the next start opens a fresh run
            if (frame_start)
                seen <= 1'b1;
            else if (ticks > 5'h0D || !clk_en)
                seen <= 1'b0;
        end
    end

    // ***************************************************************
    // properties
    // ***************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    sequence s_first_state;
        ##[0:2] (mux_state == FIRST_STATE);
    endsequence
    sequence s_start_once;
        ##1 !frame_start;
    endsequence

    property p_start_pulse; frame_start |-> s_start_once; endproperty
    a_start_pulse: assert property (p_start_pulse)
        else $error("frame start strobe longer than one cycle");
    property p_start_state; frame_start |-> s_first_state; endproperty
    a_start_state: assert property (p_start_state)
        else $error("frame did not begin at state one");
    property p_frame_ticks; (frame_start && seen) |-> ticks == 5'h0D; endproperty
    a_frame_ticks: assert property (p_frame_ticks)
        else $error("frame length not thirteen slow ticks");
    property p_state_step;
        ($changed(mux_state) && mux_state != 4'h0) |->
            (mux_state == $past(mux_state) + 4'h1 || mux_state == FIRST_STATE);
    endproperty
    a_state_step: assert property (p_state_step)
        else $error("mux state skipped or went backwards");
    property p_state_max; mux_state <= top_state; endproperty
    a_state_max: assert property (p_state_max)
        else $error("mux state above variant input count");
    property p_local_addr;
        (ram_we && ram_wr.addr != RAM_REMOTE_ADDR) |->
            (ram_wr.addr >= FIRST_STATE && ram_wr.addr <= top_state);
    endproperty
    a_local_addr: assert property (p_local_addr)
        else $error("local sample written outside slot range");
    property p_slot2_drop;
        (ram_we && afe_cfg.remote_sensor_enable) |-> ram_wr.addr != REMOTE_SLOT;
    endproperty
    a_slot2_drop: assert property (p_slot2_drop)
        else $error("slot two stored in remote mode");
    property p_remote_half;
        (ram_we && ram_wr.addr == RAM_REMOTE_ADDR) |->
            (afe_cfg.remote_sensor_enable && ticks >= 5'h07 && ticks < 5'h0D);
    endproperty
    a_remote_half: assert property (p_remote_half)
        else $error("remote sample outside second half of frame");
    property p_pair_mode;
        $past(resetn) |-> afe_cfg.second_current_local_analog != afe_cfg.remote_sensor_enable;
    endproperty
    a_pair_mode: assert property (p_pair_mode)
        else $error("second pair both or neither analog and digital");
endmodule

/* File: verification/aims_afe_model.sv */
`timescale 1ns/100ps
module aims_afe_model #(
    parameter int HALF_TICK = 10,
    parameter logic [31:0] REMOTE_WORD = 32'h5A3C96E1
) (
    // reference clock
    input wire logic ref_clk,
    // slow clock pin and converter stream
    output logic slow_clock_32k,
    output logic adc_valid,
    output logic [aims_pkg::ADC_W-1:0] adc_data,
    // remote sensor words
    output logic remote_valid,
    output logic [aims_pkg::ACC_W-1:0] remote_data
);
    import aims_pkg::*;
    int div;
    assign remote_data = REMOTE_WORD;

    initial begin
        div = 0;
        slow_clock_32k = 1'b0;
        adc_valid = 1'b0;
        adc_data = '0;
        remote_valid = 1'b0;
    end

    // slow clock scaled down so a frame costs a few hundred ref cycles
    always @(posedge ref_clk) begin
        div <= (div == HALF_TICK - 1) ? 0 : div + 1;
        if (div == HALF_TICK - 1)
            slow_clock_32k <= ~slow_clock_32k;
        remote_valid <= (div == HALF_TICK - 1) && !slow_clock_32k;
        adc_valid <= ~adc_valid;
        adc_data <= adc_data + 22'h000001;
    end
endmodule

/* File: verification/aims_sequencer_bench.sv */
`timescale 1ns/100ps
module aims_sequencer_bench;
    import aims_pkg::*;
    localparam int HALF_TICK = 10;
    localparam logic [31:0] REMOTE_WORD = 32'h5A3C96E1;
    logic ref_clk = 1'b0, resetn = 1'b0, clk_en = 1'b1;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic slow_clock_32k, adc_valid, remote_valid, frame_start, ram_we;
    logic [ADC_W-1:0] adc_data;
    logic [ACC_W-1:0] remote_data;
    logic [3:0] mux_state;
    aims_afe_cfg_s afe_cfg;
    aims_ram_wr_s ram_wr;
    int n_mismatch = 0;
    int checked = 0;
    // ctrl words, expected front end levels and expected slot addresses
    logic [31:0] case_ctrl [4] = '{32'h36, 32'h4C, 32'h10, 32'hF2};
    logic [3:0] case_afe [4] = '{4'hD, 4'h6, 4'h1, 4'h9};
    logic [15:0] case_mask [4] = '{16'h000E, 16'h011A, 16'h0002, 16'h001E};

    always #12.5 ref_clk = ~ref_clk;

    aims_sequencer uut (
        .ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .slow_clock_32k(slow_clock_32k), .adc_valid(adc_valid), .adc_data(adc_data),
        .remote_valid(remote_valid), .remote_data(remote_data), .afe_cfg(afe_cfg),
        .mux_state(mux_state), .frame_start(frame_start), .ram_we(ram_we), .ram_wr(ram_wr));

    aims_afe_model #(.HALF_TICK(HALF_TICK), .REMOTE_WORD(REMOTE_WORD)) partner (
        .ref_clk(ref_clk), .slow_clock_32k(slow_clock_32k), .adc_valid(adc_valid),
        .adc_data(adc_data), .remote_valid(remote_valid), .remote_data(remote_data));

    task automatic check(input string what, input logic [35:0] seen, input logic [35:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic finish_test;
        if (n_mismatch == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // write: both channels offered together, bready held until the answer
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_done;
        logic w_done;
        @(posedge ref_clk);
        aw_done = 1'b0;
        w_done = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hF;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge ref_clk);
            if (s_axi_awready === 1'b1) begin
                aw_done = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wready === 1'b1) begin
                w_done = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        while (s_axi_bvalid !== 1'b1) @(posedge ref_clk);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge ref_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge ref_clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        while (s_axi_rvalid !== 1'b1) @(posedge ref_clk);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    // one whole frame: from a start strobe up to the next one
    task automatic observe_frame(output logic [15:0] mask, output logic [31:0] rdat);
        mask = 16'h0000;
        rdat = 32'h0;
        do @(posedge ref_clk); while (frame_start !== 1'b1);
        do begin
            @(posedge ref_clk);
            if (ram_we === 1'b1) begin
                mask[ram_wr.addr] = 1'b1;
                if (ram_wr.addr == RAM_REMOTE_ADDR)
                    rdat = ram_wr.data;
            end
        end while (frame_start !== 1'b1);
    endtask

    // ***************************************************************
    // tests
    // ***************************************************************
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        logic [15:0] mask;
        logic [31:0] rw;
        repeat (4) @(posedge ref_clk);
        resetn <= 1'b1;
        axi_rd(ADDR_CTRL, d, r);
        check("ctrl reset", 36'({r, d}), 36'({RESP_OKAY, CTRL_RESET}));
        check("afe reset", 36'(afe_cfg), 36'h1);
        axi_rd(ADDR_STATUS, d, r);
        check("status reset", 36'({r, d}), 36'({RESP_OKAY, 32'h0}));
        axi_rd(4'hC, d, r);
        check("unmapped read", 36'({r, d}), 36'({RESP_SLVERR, 32'h0}));
        axi_wr(ADDR_STATUS, 32'hFFFFFFFF, r);
        check("ro write resp", 36'(r), 36'(RESP_SLVERR));
        axi_rd(ADDR_CTRL, d, r);
        check("ctrl kept", 36'(d), 36'(CTRL_RESET));
        // four front end modes and state counts of 1, 3 and 4, configured while idle
        for (int i = 0; i < 4; i++) begin
            axi_wr(ADDR_CTRL, case_ctrl[i], r);
            repeat (2) @(posedge ref_clk);
            check("afe cfg", 36'(afe_cfg), 36'(case_afe[i]));
            axi_wr(ADDR_CTRL, case_ctrl[i] | 32'h1, r);
            observe_frame(mask, rw);
            check("slots", 36'(mask), 36'(case_mask[i]));
            if (case_ctrl[i][CTRL_RMT]) begin
                check("remote sample", 36'(rw), 36'(REMOTE_WORD));
                axi_rd(ADDR_REMOTE, d, r);
                check("remote reg", 36'(d), 36'(REMOTE_WORD));
            end
            axi_wr(ADDR_CTRL, case_ctrl[i], r);
            // idle well past a frame so the next run starts fresh
            repeat (30 * HALF_TICK) @(posedge ref_clk);
        end
        // a low clock enable must hold the sequencer inside slot one
        axi_wr(ADDR_CTRL, 32'h37, r);
        do @(posedge ref_clk); while (frame_start !== 1'b1);
        repeat (HALF_TICK) @(posedge ref_clk);
        clk_en <= 1'b0;
        repeat (10 * HALF_TICK) @(posedge ref_clk);
        check("frozen state", 36'(mux_state), 36'(FIRST_STATE));
        clk_en <= 1'b1;
        axi_wr(ADDR_CTRL, 32'h36, r);
        finish_test();
    end

    // watchdog, several times the expected run length
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_mismatch++;
        finish_test();
    end
endmodule

bind aims_sequencer aims_sequencer_asserts #(.HAS_SECOND_VOLTAGE(HAS_SECOND_VOLTAGE)) u_chk (
    .ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en),
    .slow_clock_32k(slow_clock_32k), .afe_cfg(afe_cfg),
    .mux_state(mux_state), .frame_start(frame_start), .ram_we(ram_we), .ram_wr(ram_wr));
